// *** logic/osdreg_params.svh ***
// Register offsets, field positions and timing figures for the OSD register bank.
// Assumes inclusion by the package and the principal design file only.
`ifndef OSDREG_PARAMS_SVH
`define OSDREG_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OSDREG_ADDR_FRAME1 16'h8400
`define OSDREG_ADDR_FRAME2 16'h8401
`define OSDREG_ADDR_FONT_ACC 16'h8402
`define OSDREG_ADDR_VBLANK 16'h8403
`define OSDREG_ADDR_HEIGHT 16'h8404
`define OSDREG_ADDR_HL_LO 16'h8405
`define OSDREG_ADDR_HL_HI 16'h8406
`define OSDREG_ADDR_LL_LO 16'h8407
`define OSDREG_ADDR_LL_HI 16'h8408
`define OSDREG_ADDR_SH_LO 16'h8409
`define OSDREG_ADDR_SH_HI 16'h840a
`define OSDREG_ADDR_CKS_START 16'h840d
`define OSDREG_ADDR_CKS_LO 16'h840e
`define OSDREG_ADDR_CKS_HI 16'h840f
`define OSDREG_ADDR_HPOS1 16'h8410

// ****************************************
// Fields, reset values and ranges
// ****************************************
`define OSDREG_RESET_BYTE 8'h00
`define OSDREG_RESET_WORD 16'h0000
`define OSDREG_BIT_PLANE 0
`define OSDREG_BIT_CODE_OR_ATTRIBUTE_BIT 1
`define OSDREG_BIT_OSD_EN 0
`define OSDREG_BIT_WIN1_EN 1
`define OSDREG_BIT_WIN2_EN 2
`define OSDREG_BIT_RUN 0
`define OSDREG_COLOR_PLANE_BIT_CODE_OR_ATTRIBUTE_BIT_LO 16'h3000
`define OSDREG_COLOR_PLANE_BIT_CODE_OR_ATTRIBUTE_BIT_HI 16'h3fff
`define OSDREG_COLOR_PLANE_BIT_FONT_LO 16'h7000
`define OSDREG_COLOR_PLANE_BIT_FONT_HI 16'h7fff
`define OSDREG_PAGE_LO 16'h8000
`define OSDREG_PAGE_HI 16'h81ff
`define OSDREG_LINE_BASE 11'h2c0
`define OSDREG_LINE_SHIFT 6
`define OSDREG_HPOS_OFFSET 11'h01e
`define OSDREG_HPOS_EARLIEST 11'h02a
`define OSDREG_CKS_MOD_ONE 16'hffff
`define OSDREG_CKS_WORDS 4608
`endif

// *** logic/osdreg_pkg.sv ***
// Types shared by the OSD register bank.
// Assumes osdreg_params.svh sits on the include path.
`include "osdreg_params.svh"
package osdreg_pkg;
	typedef enum logic [1:0] {
		OSDREG_IDLE = 2'h0,
		OSDREG_RUN = 2'h1,
		OSDREG_DRAIN = 2'h3,
		OSDREG_DONE = 2'h2
	} osdreg_state_t;

	typedef struct packed {
		logic [7:0] frame1;
		logic [7:0] frame2;
		logic [1:0] font_acc;
		logic [6:0] blank_line_count;
		logic [7:0] height_value;
		logic [8:0] highlight;
		logic [8:0] lowlight;
		logic [8:0] shade;
		logic [7:0] hpos_value;
		osdreg_state_t cks_state;
		logic [12:0] rom_addr;
		logic rom_pend;
		logic [15:0] cks_acc;
		logic [15:0] cks_result;
		logic vb_active;
		logic [6:0] vb_lines;
		logic [7:0] reg_rdata;
		logic [7:0] mem_rdata;
	} osdreg_state_vec_t;
endpackage : osdreg_pkg

// *** logic/osdreg_bank.sv ***
// OSD control register bank: host register file, plane routing, blanking, ROM checksum.
// Assumes the serial control front end delivers decoded 16-bit address byte accesses.
// Functional notes
// - Line length code gives 704 plus 64 per step
// - Four-colour attribute access uses selected plane
// - Four-colour font reads return selected plane
// - Page reads return code or attribute
// - Vertical blank lasts programmed scan lines
// - Height lines equal four times value
// - Highlight colour is green red blue 9-bit
// - Lowlight colour uses same 9-bit layout
// - Shade colour uses same 9-bit layout
// - Run bit starts sequential ROM checksum
// - Result stored modulo 65535, run bit self-clears
// - Result read as low and high bytes
// - Two windows shown together or alone
// - Window one starts at four times value plus thirty
// - Window output never starts before pixel 42
// - Line code bits 7-5, blink period 4-0
`timescale 1ns/1ps
`include "osdreg_params.svh"

module osdreg_bank
	import osdreg_pkg::*;
#(
	parameter int CKS_WORDS = `OSDREG_CKS_WORDS
)
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic [7:0] font_data,
	input wire logic [7:0] page_char_data,
	input wire logic [7:0] page_code_or_attribute_bit_data,
	output logic font_plane_msb,
	output logic page_code_or_attribute_bit_sel,
	output logic [7:0] mem_rdata,
	output logic [12:0] rom_addr,
	output logic rom_rd,
	input wire logic [15:0] rom_data,
	input wire logic vblank_enable,
	input wire logic vflyback_pulse,
	input wire logic hsync_pulse,
	output logic vblank,
	output logic [10:0] line_pixels,
	output logic [4:0] blink_period_field,
	output logic [9:0] height_lines,
	output logic [8:0] highlight_color,
	output logic [8:0] lowlight_color,
	output logic [8:0] shade_color,
	output logic [10:0] win1_start_px,
	output logic win1_enable,
	output logic win2_enable
);

	osdreg_state_vec_t s_ff;
	osdreg_state_vec_t nxt_s;
	logic in_attr4;
	logic in_color_plane_bit;
	logic in_page;
	logic [10:0] hpos_raw;
	logic [16:0] sum17;
	logic [15:0] folded;

	// ****************************************
	// Memory access routing
	// ****************************************
	assign in_attr4 = (mem_addr >= `OSDREG_COLOR_PLANE_BIT_CODE_OR_ATTRIBUTE_BIT_LO) && (mem_addr <= `OSDREG_COLOR_PLANE_BIT_CODE_OR_ATTRIBUTE_BIT_HI);
	assign in_color_plane_bit = (mem_addr >= `OSDREG_COLOR_PLANE_BIT_FONT_LO) && (mem_addr <= `OSDREG_COLOR_PLANE_BIT_FONT_HI);
	assign in_page = (mem_addr >= `OSDREG_PAGE_LO) && (mem_addr <= `OSDREG_PAGE_HI);
	// Two-colour range gets the plane bit held low whatever the host writes
	assign font_plane_msb = (in_attr4 || in_color_plane_bit) && s_ff.font_acc[`OSDREG_BIT_PLANE];
	assign page_code_or_attribute_bit_sel = in_page && s_ff.font_acc[`OSDREG_BIT_CODE_OR_ATTRIBUTE_BIT];
	assign mem_rdata = s_ff.mem_rdata;

	// ****************************************
	// Display settings
	// ****************************************
	assign line_pixels = `OSDREG_LINE_BASE
		+ (11'(s_ff.frame2[7:5]) << `OSDREG_LINE_SHIFT);
	assign blink_period_field = s_ff.frame2[4:0];
	assign height_lines = {s_ff.height_value, 2'h0};
	assign highlight_color = s_ff.highlight;
	assign lowlight_color = s_ff.lowlight;
	assign shade_color = s_ff.shade;
	// Top values reach 1050, so one extra bit above the 10 a start would seem to need
	assign hpos_raw = {1'b0, s_ff.hpos_value, 2'h0} + `OSDREG_HPOS_OFFSET;
	// Pipeline latency hides anything earlier than this
	assign win1_start_px = (hpos_raw < `OSDREG_HPOS_EARLIEST) ? `OSDREG_HPOS_EARLIEST
		: hpos_raw;
	assign win1_enable = s_ff.frame1[`OSDREG_BIT_OSD_EN] && s_ff.frame1[`OSDREG_BIT_WIN1_EN];
	assign win2_enable = s_ff.frame1[`OSDREG_BIT_OSD_EN] && s_ff.frame1[`OSDREG_BIT_WIN2_EN];
	assign vblank = s_ff.vb_active;
	assign reg_rdata = s_ff.reg_rdata;
	assign rom_addr = s_ff.rom_addr;
	assign rom_rd = (s_ff.cks_state == OSDREG_RUN);

	// End-around carry keeps the sum modulo 65535
	assign sum17 = {1'b0, s_ff.cks_acc} + {1'b0, rom_data};
	assign folded = sum17[15:0] + {15'h0000, sum17[16]};

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.reg_rdata = `OSDREG_RESET_BYTE;
		// Reserved bits are dropped, so stray host writes cannot leak
		if (reg_wr)
		begin
			case (reg_addr)
				`OSDREG_ADDR_FRAME1: nxt_s.frame1 = reg_wdata;
				`OSDREG_ADDR_FRAME2: nxt_s.frame2 = reg_wdata;
				`OSDREG_ADDR_FONT_ACC: nxt_s.font_acc = reg_wdata[1:0];
				`OSDREG_ADDR_VBLANK: nxt_s.blank_line_count = reg_wdata[6:0];
				`OSDREG_ADDR_HEIGHT: nxt_s.height_value = reg_wdata;
				`OSDREG_ADDR_HL_LO: nxt_s.highlight[7:0] = reg_wdata;
				`OSDREG_ADDR_HL_HI: nxt_s.highlight[8] = reg_wdata[0];
				`OSDREG_ADDR_LL_LO: nxt_s.lowlight[7:0] = reg_wdata;
				`OSDREG_ADDR_LL_HI: nxt_s.lowlight[8] = reg_wdata[0];
				`OSDREG_ADDR_SH_LO: nxt_s.shade[7:0] = reg_wdata;
				`OSDREG_ADDR_SH_HI: nxt_s.shade[8] = reg_wdata[0];
				`OSDREG_ADDR_HPOS1: nxt_s.hpos_value = reg_wdata;
				default: nxt_s.hpos_value = s_ff.hpos_value;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				`OSDREG_ADDR_FRAME1: nxt_s.reg_rdata = s_ff.frame1;
				`OSDREG_ADDR_FRAME2: nxt_s.reg_rdata = s_ff.frame2;
				`OSDREG_ADDR_FONT_ACC: nxt_s.reg_rdata = {6'h00, s_ff.font_acc};
				`OSDREG_ADDR_VBLANK: nxt_s.reg_rdata = {1'b0, s_ff.blank_line_count};
				`OSDREG_ADDR_HEIGHT: nxt_s.reg_rdata = s_ff.height_value;
				`OSDREG_ADDR_HL_LO: nxt_s.reg_rdata = s_ff.highlight[7:0];
				`OSDREG_ADDR_HL_HI: nxt_s.reg_rdata = {7'h00, s_ff.highlight[8]};
				`OSDREG_ADDR_LL_LO: nxt_s.reg_rdata = s_ff.lowlight[7:0];
				`OSDREG_ADDR_LL_HI: nxt_s.reg_rdata = {7'h00, s_ff.lowlight[8]};
				`OSDREG_ADDR_SH_LO: nxt_s.reg_rdata = s_ff.shade[7:0];
				`OSDREG_ADDR_SH_HI: nxt_s.reg_rdata = {7'h00, s_ff.shade[8]};
				`OSDREG_ADDR_CKS_START:
					nxt_s.reg_rdata = {7'h00, s_ff.cks_state != OSDREG_IDLE};
				`OSDREG_ADDR_CKS_LO: nxt_s.reg_rdata = s_ff.cks_result[7:0];
				`OSDREG_ADDR_CKS_HI: nxt_s.reg_rdata = s_ff.cks_result[15:8];
				`OSDREG_ADDR_HPOS1: nxt_s.reg_rdata = s_ff.hpos_value;
				default: nxt_s.reg_rdata = `OSDREG_RESET_BYTE;
			endcase
		end

		if (mem_rd)
		begin
			if (in_page)
				nxt_s.mem_rdata = s_ff.font_acc[`OSDREG_BIT_CODE_OR_ATTRIBUTE_BIT] ? page_code_or_attribute_bit_data
					: page_char_data;
			else
				nxt_s.mem_rdata = font_data;
		end

		// Vertical blanking counted in scan lines from flyback
		if (vflyback_pulse && vblank_enable && (s_ff.blank_line_count != 7'h00))
		begin
			nxt_s.vb_active = 1'b1;
			nxt_s.vb_lines = 7'h00;
		end
		else if (!vblank_enable)
			nxt_s.vb_active = 1'b0;
		else if (s_ff.vb_active && hsync_pulse)
		begin
			nxt_s.vb_lines = s_ff.vb_lines + 7'h01;
			if ((s_ff.vb_lines + 7'h01) >= s_ff.blank_line_count)
				nxt_s.vb_active = 1'b0;
		end

		// ROM data returns one cycle after the read strobe
		nxt_s.rom_pend = (s_ff.cks_state == OSDREG_RUN);
		if (s_ff.rom_pend)
			nxt_s.cks_acc = folded;
		case (s_ff.cks_state)
			OSDREG_IDLE:
			begin
				// Writing zero cannot abort a run in progress
				if (reg_wr && (reg_addr == `OSDREG_ADDR_CKS_START)
					&& reg_wdata[`OSDREG_BIT_RUN])
				begin
					nxt_s.cks_state = OSDREG_RUN;
					nxt_s.rom_addr = 13'h0000;
					nxt_s.cks_acc = `OSDREG_RESET_WORD;
				end
			end
			OSDREG_RUN:
			begin
				nxt_s.rom_addr = s_ff.rom_addr + 13'h0001;
				if (s_ff.rom_addr == 13'(CKS_WORDS - 1))
					nxt_s.cks_state = OSDREG_DRAIN;
			end
			OSDREG_DRAIN: nxt_s.cks_state = OSDREG_DONE;
			OSDREG_DONE:
			begin
				nxt_s.cks_result = (s_ff.cks_acc == `OSDREG_CKS_MOD_ONE) ? `OSDREG_RESET_WORD
					: s_ff.cks_acc;
				nxt_s.cks_state = OSDREG_IDLE;
			end
			default: nxt_s.cks_state = OSDREG_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_line_max;
		(s_ff.frame2[7:5] == 3'h7) |-> (line_pixels == 11'h480);
	endproperty
	a_line_max: assert property (p_line_max) else $error("Code 7 not 1152 pixels");

	property p_attr4_plane;
		in_attr4 |-> (font_plane_msb == s_ff.font_acc[0]);
	endproperty
	a_attr4_plane: assert property (p_attr4_plane) else $error("Code_or_attribute_bit plane misrouted");

	property p_color_plane_bit_plane;
		in_color_plane_bit |-> (font_plane_msb == s_ff.font_acc[`OSDREG_BIT_PLANE]);
	endproperty
	a_color_plane_bit_plane: assert property (p_color_plane_bit_plane) else $error("Font plane misrouted");

	property p_page_code_or_attribute_bit;
		(mem_rd && in_page && s_ff.font_acc[1]) |=> (mem_rdata == $past(page_code_or_attribute_bit_data));
	endproperty
	a_page_code_or_attribute_bit: assert property (p_page_code_or_attribute_bit) else $error("Page code_or_attribute_bit not returned");

	property p_vb_start;
		(vflyback_pulse && vblank_enable && s_ff.blank_line_count != 7'h00) |=> vblank;
	endproperty
	a_vb_start: assert property (p_vb_start) else $error("Blank did not start");

	property p_cks_start;
		(reg_wr && reg_addr == `OSDREG_ADDR_CKS_START && reg_wdata[0] && !rom_rd
			&& s_ff.cks_state == OSDREG_IDLE) |=> rom_rd && rom_addr == 13'h0000;
	endproperty
	a_cks_start: assert property (p_cks_start) else $error("Checksum not started");

	property p_cks_hold;
		rom_rd |=> $stable(s_ff.cks_result);
	endproperty
	a_cks_hold: assert property (p_cks_hold) else $error("Result changed mid run");

	property p_cks_clear;
		(s_ff.cks_state == OSDREG_DRAIN) |-> ##2 (s_ff.cks_state == OSDREG_IDLE)
			&& (s_ff.cks_result != `OSDREG_CKS_MOD_ONE);
	endproperty
	a_cks_clear: assert property (p_cks_clear) else $error("Run bit not cleared");

	property p_hpos;
		(s_ff.hpos_value > 8'h02)
			|-> (win1_start_px == {1'b0, s_ff.hpos_value, 2'h0} + `OSDREG_HPOS_OFFSET);
	endproperty
	a_hpos: assert property (p_hpos) else $error("Window start wrong");

	property p_hpos_min;
		win1_start_px >= `OSDREG_HPOS_EARLIEST;
	endproperty
	a_hpos_min: assert property (p_hpos_min) else $error("Window start too early");

	property p_hl_high;
		(reg_wr && reg_addr == `OSDREG_ADDR_HL_HI) |=> (highlight_color[8] == $past(reg_wdata[0]));
	endproperty
	a_hl_high: assert property (p_hl_high) else $error("Highlight green msb lost");

	property p_line_min;
		(s_ff.frame2[7:5] == 3'h0) |-> (line_pixels == 11'h2c0);
	endproperty
	a_line_min: assert property (p_line_min) else $error("Code 0 not 704 pixels");

	property p_page_char;
		(mem_rd && in_page && !s_ff.font_acc[`OSDREG_BIT_CODE_OR_ATTRIBUTE_BIT])
			|=> (mem_rdata == $past(page_char_data));
	endproperty
	a_page_char: assert property (p_page_char) else $error("Page code not returned");

	property p_vb_off;
		!vblank_enable |=> !vblank;
	endproperty
	a_vb_off: assert property (p_vb_off) else $error("Blank while disabled");

	property p_height;
		(reg_wr && reg_addr == `OSDREG_ADDR_HEIGHT)
			|=> (height_lines == {$past(reg_wdata), 2'h0});
	endproperty
	a_height: assert property (p_height) else $error("Height lines wrong");

	property p_ll_low;
		(reg_wr && reg_addr == `OSDREG_ADDR_LL_LO)
			|=> (lowlight_color[7:0] == $past(reg_wdata));
	endproperty
	a_ll_low: assert property (p_ll_low) else $error("Lowlight low byte lost");

	property p_sh_high;
		(reg_wr && reg_addr == `OSDREG_ADDR_SH_HI)
			|=> (shade_color[8] == $past(reg_wdata[0]));
	endproperty
	a_sh_high: assert property (p_sh_high) else $error("Shade green msb lost");

	property p_cks_lo_read;
		(reg_rd && reg_addr == `OSDREG_ADDR_CKS_LO)
			|=> (reg_rdata == $past(s_ff.cks_result[7:0]));
	endproperty
	a_cks_lo_read: assert property (p_cks_lo_read) else $error("Result low byte wrong");

	property p_cks_hi_read;
		(reg_rd && reg_addr == `OSDREG_ADDR_CKS_HI)
			|=> (reg_rdata == $past(s_ff.cks_result[15:8]));
	endproperty
	a_cks_hi_read: assert property (p_cks_hi_read) else $error("Result high byte wrong");

	property p_run_read;
		(reg_rd && reg_addr == `OSDREG_ADDR_CKS_START && rom_rd) |=> (reg_rdata == 8'h01);
	endproperty
	a_run_read: assert property (p_run_read) else $error("Run bit not read as one");

	property p_win_off;
		!s_ff.frame1[`OSDREG_BIT_OSD_EN] |-> (!win1_enable && !win2_enable);
	endproperty
	a_win_off: assert property (p_win_off) else $error("Window shown with display off");

	property p_blink;
		(reg_wr && reg_addr == `OSDREG_ADDR_FRAME2)
			|=> (blink_period_field == $past(reg_wdata[4:0]));
	endproperty
	a_blink: assert property (p_blink) else $error("Blink period field lost");

	c_cks_done: cover property (s_ff.cks_state == OSDREG_DONE);
	c_vblank_end: cover property (vblank ##1 !vblank);
	c_page_code_or_attribute_bit: cover property (mem_rd && in_page && s_ff.font_acc[1]);
	c_plane_msb: cover property (in_color_plane_bit && font_plane_msb);
	c_run_read: cover property (reg_rd && reg_addr == `OSDREG_ADDR_CKS_START && rom_rd);

endmodule : osdreg_bank

// *** sim/osdreg_rom_model.sv ***
// Character ROM partner: a word one cycle after each rom_rd cycle.
// Assumes rom_addr and rom_rd change only on rising edges of clock.
`timescale 1ns/1ps
module osdreg_rom_model
(
	input wire logic clock,
	input wire logic rom_rd,
	input wire logic [12:0] rom_addr,
	output logic [15:0] rom_data
);
	initial rom_data = 16'h5a5a;
	// Not read: data toggles so stale words never look valid
	always @(posedge clock)
	begin
		if (rom_rd)
			rom_data <= ({3'h0, rom_addr} * 16'h9e37) ^ 16'hf00f;
		else
			rom_data <= ~rom_data;
	end
endmodule : osdreg_rom_model

// *** sim/tb_top.sv ***
// Self-checking bench for the OSD register bank with a ROM partner.
// Assumes a short checksum run (CKS_WORDS 8) and the ROM word formula.
`timescale 1ns/1ps
module tb_top
	import osdreg_pkg::*;
;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0, mem_addr = 16'h0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, mem_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h0, font_data = 8'h0, page_char_data = 8'h0, page_code_or_attribute_bit_data = 8'h0;
	logic vblank_enable = 1'b0, vflyback_pulse = 1'b0, hsync_pulse = 1'b0;
	logic [7:0] reg_rdata, mem_rdata, q;
	logic font_plane_msb, page_code_or_attribute_bit_sel, rom_rd, vblank, win1_enable, win2_enable;
	logic [12:0] rom_addr;
	logic [15:0] rom_data;
	logic [10:0] line_pixels;
	logic [4:0] blink_period_field;
	logic [9:0] height_lines;
	logic [10:0] win1_start_px;
	logic [8:0] highlight_color, lowlight_color, shade_color;
	int n_fail = 0, num_checks = 0, seed = 20343, s;
	logic [7:0] ev [0:16];
	logic [15:0] ra [12] = '{16'h8400, 16'h8401, 16'h8402, 16'h8403, 16'h8404, 16'h8405,
		16'h8406, 16'h8407, 16'h8408, 16'h8409, 16'h840a, 16'h8410};
	logic [7:0] rm [12] = '{8'hff, 8'hff, 8'h03, 8'h7f, 8'hff, 8'hff, 8'h01, 8'hff, 8'h01,
		8'hff, 8'h01, 8'hff};
	logic [15:0] ma [7] = '{16'h1000, 16'h3000, 16'h3fff, 16'h7000, 16'h8000, 16'h81ff, 16'h8200};
	always #4 clock = ~clock;
	osdreg_bank #(.CKS_WORDS(8)) dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .font_data(font_data),
		.page_char_data(page_char_data), .page_code_or_attribute_bit_data(page_code_or_attribute_bit_data),
		.font_plane_msb(font_plane_msb), .page_code_or_attribute_bit_sel(page_code_or_attribute_bit_sel), .mem_rdata(mem_rdata),
		.rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data),
		.vblank_enable(vblank_enable), .vflyback_pulse(vflyback_pulse),
		.hsync_pulse(hsync_pulse), .vblank(vblank), .line_pixels(line_pixels),
		.blink_period_field(blink_period_field), .height_lines(height_lines),
		.highlight_color(highlight_color), .lowlight_color(lowlight_color),
		.shade_color(shade_color), .win1_start_px(win1_start_px), .win1_enable(win1_enable),
		.win2_enable(win2_enable));
	osdreg_rom_model rom (.clock(clock), .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask : rd
	task automatic pulse_h();
		@(posedge clock);
		hsync_pulse <= 1'b1;
		@(posedge clock);
		hsync_pulse <= 1'b0;
		// Line period kept above the slowest limit, 96 kHz at code 7
		repeat (1310) @(posedge clock);
		#1;
	endtask : pulse_h
	task automatic summarize();
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	// Watchdog: whole run needs a little over half of these cycles
	initial
	begin
		repeat (30000) @(posedge clock);
		n_fail++;
		summarize();
	end
	// ****
	// Scenarios
	// ****
	initial
	begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		chk(line_pixels, 16'd704);
		chk(win1_start_px, 16'd42);
		for (int r = 0; r < 4; r++)
		begin
			foreach (ra[k])
			begin
				ev[ra[k][4:0]] = $random(seed) & rm[k];
				wr(ra[k], ev[ra[k][4:0]]);
			end
			foreach (ra[k])
			begin
				rd(ra[k]);
				chk(q, ev[ra[k][4:0]]);
			end
			chk(highlight_color, {ev[6][0], ev[5]});
			chk(lowlight_color, {ev[8][0], ev[7]});
			chk(shade_color, {ev[10][0], ev[9]});
			chk(height_lines, 4 * ev[4]);
			chk(blink_period_field, ev[1][4:0]);
			chk(win1_enable, ev[0][0] & ev[0][1]);
			chk(win2_enable, ev[0][0] & ev[0][2]);
		end
		for (int c = 0; c < 8; c++)
		begin
			wr(16'h8401, 8'(c << 5));
			chk(line_pixels, 704 + 64 * c);
		end
		// Start values of two and below are left out: they clamp to 42, and only value 0 is checked, at reset
		for (int h = 3; h < 256; h += 3)
		begin
			wr(16'h8410, 8'(h));
			chk(win1_start_px, (4 * h + 30 < 42) ? 42 : 4 * h + 30);
		end
		rd(16'h8411);
		chk(q, 8'h00);
		wr(16'h840e, 8'hff);
		rd(16'h840e);
		chk(q, 8'h00);
		// Plane and code/attribute routing for every selector value
		for (int p = 0; p < 4; p++)
		begin
			wr(16'h8402, 8'(p));
			foreach (ma[k])
			begin
				if (p[0] && (ma[k] < 16'h3000))
					continue;
				@(posedge clock);
				mem_addr <= ma[k];
				mem_rd <= 1'b1;
				font_data <= $random(seed);
				page_char_data <= $random(seed);
				page_code_or_attribute_bit_data <= $random(seed);
				@(posedge clock);
				mem_rd <= 1'b0;
				#1;
				s = (ma[k] >= 16'h8000 && ma[k] <= 16'h81ff);
				// Only the four-colour ranges of this address list begin with 0x3 or 0x7
				chk(font_plane_msb, p[0] & (ma[k][13:12] == 2'h3));
				chk(page_code_or_attribute_bit_sel, p[1] & s);
				chk(mem_rdata, s ? (p[1] ? page_code_or_attribute_bit_data : page_char_data) : font_data);
			end
		end
		// Checksum run: run bit reads one, result held, then mod 65535
		wr(16'h840d, 8'h01);
		rd(16'h840d);
		chk(q, 8'h01);
		rd(16'h840e);
		chk(q, 8'h00);
		// Poll from a fresh run-bit read, not from the result byte just read
		rd(16'h840d);
		for (int i = 0; i < 50 && q !== 8'h00; i++)
			rd(16'h840d);
		chk(q, 8'h00);
		s = 0;
		for (int i = 0; i < 8; i++)
			s += ((i * 32'h9e37) & 32'hffff) ^ 32'hf00f;
		s = s % 65535;
		rd(16'h840e);
		chk(q, s[7:0]);
		rd(16'h840f);
		chk(q, s[15:8]);
		// Vertical blank: disabled first, then twelve lines
		wr(16'h8403, 8'h0c);
		for (int e = 0; e < 2; e++)
		begin
			@(posedge clock);
			vblank_enable <= e[0];
			vflyback_pulse <= 1'b1;
			@(posedge clock);
			vflyback_pulse <= 1'b0;
			@(posedge clock);
			#1 chk(vblank, e[0]);
		end
		repeat (11) pulse_h();
		@(posedge clock);
		#1 chk(vblank, 1'b1);
		pulse_h();
		@(posedge clock);
		#1 chk(vblank, 1'b0);
		summarize();
	end
endmodule : tb_top
